// *** hw/tisc_pkg.sv ***
// package of constants and types for the temperature input status and scaling link
package tisc_pkg;
	localparam int NCH = 4;
	localparam int STAT_W = 8;
	localparam int STAT_MOD_BIT = 7;
	typedef logic signed [15:0] tisc_word_t;
	typedef logic signed [23:0] tisc_real_t;
	typedef logic signed [31:0] tisc_eng_t;
	typedef logic [NCH-1:0][15:0] tisc_words_t;
	typedef logic [NCH-1:0][23:0] tisc_reals_t;
	typedef logic [NCH-1:0][31:0] tisc_engs_t;
	typedef enum logic [1:0] {TISC_TC, TISC_RTD, TISC_NTC, TISC_VOLT} tisc_type_t;
	localparam logic signed [31:0] WORD_MAX = 32'sd32767;
	localparam logic signed [31:0] WORD_MIN = -32'sd32768;
	localparam logic signed [31:0] REAL_MAX = 32'sd8388607;
	localparam logic signed [31:0] REAL_MIN = -32'sd8388608;
	localparam logic signed [31:0] HUND_PER_COUNT = 32'sd10;
	localparam logic signed [31:0] HALF_COUNT = 32'sd5;
	localparam logic signed [31:0] F_OFFSET = 32'sd3200;
	// register byte offsets of the host controller
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CHCFG = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_IST = 8'h0c;
	localparam logic [7:0] REG_IMASK = 8'h10;
	localparam logic [7:0] REG_ENG_MIN = 8'h14;
	localparam logic [7:0] REG_ENG_MAX = 8'h18;
	localparam logic [7:0] REG_RAW_LIM = 8'h1c;
	localparam logic [7:0] REG_WORD0 = 8'h20;
	localparam logic [7:0] REG_REAL0 = 8'h30;
	localparam logic [7:0] REG_ENG0 = 8'h40;
	localparam int CTRL_FAHR = 0;
	localparam int CTRL_REJ60 = 1;
	localparam int CTRL_CLAMP = 2;
	localparam logic [8:0] CHCFG_RST = 9'h000;
	// limits in hundredths of a degree Celsius, indexed by type and range
	function automatic logic [63:0] tisc_limits(input logic [1:0] typ, input logic [1:0] rng);
		logic [3:0] k;
		k = {typ, rng};
		case (k)
			4'h0:    tisc_limits = {-32'sd21000, 32'sd120000};
			4'h1:    tisc_limits = {-32'sd26500, 32'sd137200};
			4'h2:    tisc_limits = {32'sd4000, 32'sd182000};
			4'h3:    tisc_limits = {-32'sd26500, 32'sd40000};
			4'h4:    tisc_limits = {-32'sd20000, 32'sd85000};
			4'h5:    tisc_limits = {-32'sd8000, 32'sd26000};
			4'h8,
			4'h9,
			4'ha,
			4'hb:    tisc_limits = {-32'sd4000, 32'sd15000};
			default: tisc_limits = {-32'sd3276800, 32'sd3276700};
		endcase
	endfunction : tisc_limits
endpackage : tisc_pkg

// *** hw/tisc_link_if.sv ***
// interface joining the module end and the host controller end
`timescale 1ns/10ps
interface tisc_link_if;
	import tisc_pkg::*;
	logic              cfg_wr;
	logic              cfg_all;
	logic [1:0]        cfg_chan;
	logic              cfg_en;
	logic [1:0]        cfg_type;
	logic [1:0]        cfg_range;
	logic              cfg_bo_en;
	logic              glb_fahr;
	logic              glb_rej60;
	logic              scl_clamp;
	tisc_eng_t         scl_eng_min;
	tisc_eng_t         scl_eng_max;
	tisc_word_t        scl_raw_min;
	tisc_word_t        scl_raw_max;
	tisc_engs_t        eng_out;
	logic [STAT_W-1:0] status;
	logic              upd;
	tisc_words_t       word_val;
	tisc_reals_t       real_val;
	modport dev (input cfg_wr, cfg_all, cfg_chan, cfg_en, cfg_type, cfg_range, cfg_bo_en, glb_fahr, glb_rej60,
		scl_clamp, scl_eng_min, scl_eng_max, scl_raw_min, scl_raw_max, eng_out,
		output status, upd, word_val, real_val);
	modport host (output cfg_wr, cfg_all, cfg_chan, cfg_en, cfg_type, cfg_range, cfg_bo_en, glb_fahr, glb_rej60,
		scl_clamp, scl_eng_min, scl_eng_max, scl_raw_min, scl_raw_max, eng_out,
		input status, upd, word_val, real_val);
endinterface : tisc_link_if

// *** hw/tisc_module_end.sv ***
// module end: per-channel config, conversion, status byte and output scaling
`timescale 1ns/10ps
module tisc_module_end
(
	// clock and reset
	input  wire logic                  i_clk_sys,
	input  wire logic                  i_rstn,
	// link to host
	tisc_link_if.dev                   link,
	// front-end samples
	input  wire logic                  i_smp_vld,
	input  wire logic [1:0]            i_smp_chan,
	input  wire logic signed [31:0]    i_smp_value,
	input  wire logic                  i_smp_open,
	// analog outputs and filter setting
	output      tisc_pkg::tisc_words_t o_raw_output_word,
	output      logic                  o_rej60
);
	import tisc_pkg::*;

	typedef struct packed {
		logic [NCH-1:0]      en;
		logic [NCH-1:0][1:0] typ;
		logic [NCH-1:0][1:0] rng;
		logic [NCH-1:0]      bo_en;
		logic [NCH-1:0]      oor;
		logic [NCH-1:0]      bo;
		tisc_words_t         word;
		tisc_reals_t         rval;
		tisc_words_t         raw;
		logic                upd;
		logic                rej60;
	} tisc_dev_t;

	tisc_dev_t         s_r;
	tisc_dev_t         s_nxt;
	tisc_words_t       scl_raw;
	logic signed [31:0] v_unit;
	logic signed [31:0] v_cnt;
	logic [63:0]       lim;
	logic [1:0]        c;

	// output scaling per channel
	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : g_scl
			logic signed [63:0] num;
			logic signed [63:0] den;
			logic signed [63:0] res;
			logic signed [63:0] lo;
			logic signed [63:0] hi;
			always_comb
			begin
				lo = 64'(link.scl_raw_min);
				hi = 64'(link.scl_raw_max);
				if (lo > hi)
				begin
					lo = 64'(link.scl_raw_max);
					hi = 64'(link.scl_raw_min);
				end
				num = (64'(signed'(link.eng_out[g])) - 64'(link.scl_eng_min)) * (64'(link.scl_raw_max) - 64'(link.scl_raw_min));
				den = 64'(link.scl_eng_max) - 64'(link.scl_eng_min);
				res = (den == 64'sh0) ? 64'(link.scl_raw_min) : 64'(link.scl_raw_min) + num / den;
				if (link.scl_clamp && res > hi)
				begin
					res = hi;
				end
				if (link.scl_clamp && res < lo)
				begin
					res = lo;
				end
				if (res > 64'(WORD_MAX))
				begin
					res = 64'(WORD_MAX);
				end
				if (res < 64'(WORD_MIN))
				begin
					res = 64'(WORD_MIN);
				end
				scl_raw[g] = res[15:0];
			end
		end
	endgenerate

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.upd = 1'b0;
		s_nxt.raw = scl_raw;
		s_nxt.rej60 = link.glb_rej60;
		c = i_smp_chan;
		lim = tisc_limits(s_r.typ[c], s_r.rng[c]);
		// global temperature scale, hundredths of a degree
		v_unit = link.glb_fahr ? (i_smp_value * 32'sd9) / 32'sd5 + F_OFFSET : i_smp_value;
		// word resolution is one tenth of a unit for every range, rounded
		v_cnt = (v_unit + (v_unit < 0 ? -HALF_COUNT : HALF_COUNT)) / HUND_PER_COUNT;
		// settings for one channel or for all
		if (link.cfg_wr)
		begin
			for (int i = 0; i < NCH; i++)
			begin
				if (link.cfg_all || link.cfg_chan == 2'(i))
				begin
					s_nxt.en[i] = link.cfg_en;
					s_nxt.typ[i] = link.cfg_type;
					s_nxt.rng[i] = link.cfg_range;
					s_nxt.bo_en[i] = link.cfg_bo_en;
					if (!link.cfg_en)
					begin
						s_nxt.oor[i] = 1'b0;
						s_nxt.bo[i] = 1'b0;
						s_nxt.word[i] = 16'h0000;
						s_nxt.rval[i] = 24'h000000;
					end
				end
			end
		end
		else if (i_smp_vld && s_r.en[c])
		begin
			s_nxt.upd = 1'b1;
			s_nxt.word[c] = v_cnt > WORD_MAX ? 16'h7fff : v_cnt < WORD_MIN ? 16'h8000 : v_cnt[15:0];
			s_nxt.rval[c] = v_unit > REAL_MAX ? 24'h7fffff : v_unit < REAL_MIN ? 24'h800000 : v_unit[23:0];
			s_nxt.oor[c] = !i_smp_open && (i_smp_value < signed'(lim[63:32]) ||
				i_smp_value > signed'(lim[31:0]));
			s_nxt.bo[c] = i_smp_open && s_r.bo_en[c];
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			s_r <= '0;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// status byte: burnout/range pairs, channel four on top down to channel one at the bottom
	always_comb
	begin
		for (int i = 0; i < NCH; i++)
		begin
			link.status[2*i+1] = s_r.bo[i];
			link.status[2*i] = s_r.oor[i];
		end
	end

	assign link.upd = s_r.upd;
	assign link.word_val = s_r.word;
	assign link.real_val = s_r.rval;
	assign o_raw_output_word = s_r.raw;
	assign o_rej60 = s_r.rej60;
endmodule : tisc_module_end

// *** hw/tisc_host_end.sv ***
// host controller end: software registers, configuration writes, status interrupt
`timescale 1ns/10ps
module tisc_host_end
(
	// clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rstn,
	// software register port
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output      logic [31:0] o_rdata,
	// interrupt
	output      logic        o_irq,
	// link to module
	tisc_link_if.host        link
);
	import tisc_pkg::*;

	typedef struct packed {
		logic [2:0]        ctrl;
		logic [8:0]        chcfg;
		logic              cfg_wr;
		logic [STAT_W-1:0] ist;
		logic [STAT_W-1:0] imask;
		tisc_eng_t         emin;
		tisc_eng_t         emax;
		tisc_word_t        rmin;
		tisc_word_t        rmax;
		tisc_engs_t        eng;
		logic [31:0]       rdata;
	} tisc_host_t;

	tisc_host_t  s_r;
	tisc_host_t  s_nxt;
	logic [31:0] rd_val;
	logic [1:0]  n;

	always_comb
	begin
		n = i_addr[3:2];
		case (i_addr)
			REG_CTRL:    rd_val = {29'h0, s_r.ctrl};
			REG_CHCFG:   rd_val = {23'h0, s_r.chcfg};
			REG_STATUS:  rd_val = {24'h0, link.status};
			REG_IST:     rd_val = {24'h0, s_r.ist};
			REG_IMASK:   rd_val = {24'h0, s_r.imask};
			REG_ENG_MIN: rd_val = s_r.emin;
			REG_ENG_MAX: rd_val = s_r.emax;
			REG_RAW_LIM: rd_val = {s_r.rmax, s_r.rmin};
			default:
			begin
				if (i_addr[7:4] == REG_WORD0[7:4] && i_addr[1:0] == 2'h0)
				begin
					rd_val = {{16{link.word_val[n][15]}}, link.word_val[n]};
				end
				else if (i_addr[7:4] == REG_REAL0[7:4] && i_addr[1:0] == 2'h0)
				begin
					rd_val = {{8{link.real_val[n][23]}}, link.real_val[n]};
				end
				else if (i_addr[7:4] == REG_ENG0[7:4] && i_addr[1:0] == 2'h0)
				begin
					rd_val = s_r.eng[n];
				end
				else
				begin
					rd_val = 32'h0000_0000;
				end
			end
		endcase
		s_nxt = s_r;
		s_nxt.cfg_wr = 1'b0;
		s_nxt.rdata = i_rd ? rd_val : 32'h0000_0000;
		if (i_wr && i_addr == REG_IST)
		begin
			s_nxt.ist = s_r.ist & ~i_wdata[STAT_W-1:0];
		end
		if (link.upd)
		begin
			s_nxt.ist = s_nxt.ist | link.status;
		end
		if (i_wr)
		begin
			case (i_addr)
				REG_CTRL:    s_nxt.ctrl = i_wdata[2:0];
				REG_CHCFG:
				begin
					s_nxt.chcfg = i_wdata[8:0];
					s_nxt.cfg_wr = 1'b1;
				end
				REG_IMASK:   s_nxt.imask = i_wdata[STAT_W-1:0];
				REG_ENG_MIN: s_nxt.emin = i_wdata;
				REG_ENG_MAX: s_nxt.emax = i_wdata;
				REG_RAW_LIM:
				begin
					s_nxt.rmin = i_wdata[15:0];
					s_nxt.rmax = i_wdata[31:16];
				end
				default:
				begin
					if (i_addr[7:4] == REG_ENG0[7:4] && i_addr[1:0] == 2'h0)
					begin
						s_nxt.eng[n] = i_wdata;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			s_r <= '0;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign o_rdata = s_r.rdata;
	assign o_irq = |(s_r.ist & s_r.imask);
	assign link.cfg_wr = s_r.cfg_wr;
	assign link.cfg_chan = s_r.chcfg[1:0];
	assign link.cfg_all = s_r.chcfg[2];
	assign link.cfg_en = s_r.chcfg[3];
	assign link.cfg_type = s_r.chcfg[5:4];
	assign link.cfg_range = s_r.chcfg[7:6];
	assign link.cfg_bo_en = s_r.chcfg[8];
	assign link.glb_fahr = s_r.ctrl[CTRL_FAHR];
	assign link.glb_rej60 = s_r.ctrl[CTRL_REJ60];
	assign link.scl_clamp = s_r.ctrl[CTRL_CLAMP];
	assign link.scl_eng_min = s_r.emin;
	assign link.scl_eng_max = s_r.emax;
	assign link.scl_raw_min = s_r.rmin;
	assign link.scl_raw_max = s_r.rmax;
	assign link.eng_out = s_r.eng;
endmodule : tisc_host_end

// *** verif/tisc_monitor.sv ***
// concurrent checks on the link between module end and host end
`timescale 1ns/10ps
module tisc_monitor
	import tisc_pkg::*;
(
	// clock and reset
	input wire logic              i_clk_sys,
	input wire logic              i_rstn,
	// link signals
	input wire logic              cfg_wr,
	input wire logic              cfg_all,
	input wire logic [1:0]        cfg_chan,
	input wire logic              cfg_en,
	input wire logic [STAT_W-1:0] status,
	input wire logic              upd,
	input wire tisc_words_t       word_val,
	input wire tisc_reals_t       real_val
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rstn);
	top_pair_clr_a: assert property (cfg_wr && !cfg_en && (cfg_all || cfg_chan == 2'h3) |=> status[7:6] == 2'b00)
		else $error("channel four flags not cleared");
	flag_pair_a: assert property (status[1:0] != 2'b11 && status[7:6] != 2'b11)
		else $error("burnout and range flags both set");
	cfg_pulse_a: assert property (cfg_wr |=> !cfg_wr)
		else $error("config strobe longer than one cycle");
	word_sat_a: assert property ($signed(real_val[1]) >= 24'sd327675 |-> word_val[1] == 16'h7fff)
		else $error("word not saturated");
	word_sign_a: assert property ($signed(real_val[0]) <= -24'sd5 |-> word_val[0][15])
		else $error("word sign wrong");
	word_round_a: assert property ($signed(real_val[0]) > -24'sd5 && $signed(real_val[0]) < 24'sd5
		|-> word_val[0] == 16'h0) else $error("word rounding wrong");
	disable_clr_a: assert property (cfg_wr && !cfg_en && (cfg_all || cfg_chan == 2'h0)
		|=> status[1:0] == 2'b00 && word_val[0] == 16'h0 && real_val[0] == 24'h0) else $error("disable kept values");
	hold_vals_a: assert property (!upd && !$past(cfg_wr) |-> $stable(status) && $stable(word_val))
		else $error("values changed without update");
	cover property (upd);
	cover property (status[STAT_MOD_BIT]);
	cover property (cfg_wr && cfg_all);
endmodule : tisc_monitor

// *** verif/temp_input_status_scaling_bench.sv ***
// self-checking bench for the temperature status and scaling link
`timescale 1ns/10ps
module temp_input_status_scaling_bench;
	import tisc_pkg::*;
	logic               i_clk_sys = 1'b0;
	logic               i_rstn = 1'b0;
	logic [7:0]         i_addr = 8'h00;
	logic [31:0]        i_wdata = 32'h0;
	logic               i_wr = 1'b0;
	logic               i_rd = 1'b0;
	logic               i_smp_vld = 1'b0;
	logic [1:0]         i_smp_chan = 2'h0;
	logic signed [31:0] i_smp_value = 32'h0;
	logic               i_smp_open = 1'b0;
	logic [31:0]        o_rdata;
	logic               o_irq;
	logic               o_rej60;
	tisc_words_t        o_raw_output_word;
	int                 error_cnt = 0;
	int                 tests_run = 0;
	int                 cyc = 0;
	always #10 i_clk_sys = ~i_clk_sys;
	tisc_link_if link ();
	tisc_module_end tisc_module_end_inst (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .link(link.dev),
		.i_smp_vld(i_smp_vld), .i_smp_chan(i_smp_chan), .i_smp_value(i_smp_value), .i_smp_open(i_smp_open),
		.o_raw_output_word(o_raw_output_word), .o_rej60(o_rej60));
	tisc_host_end tisc_host_end_inst (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .link(link.host));
	tisc_monitor tisc_monitor_inst (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .cfg_wr(link.cfg_wr),
		.cfg_all(link.cfg_all), .cfg_chan(link.cfg_chan), .cfg_en(link.cfg_en), .status(link.status),
		.upd(link.upd), .word_val(link.word_val), .real_val(link.real_val));
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test
	always @(posedge i_clk_sys)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			error_cnt++;
			end_of_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
		@(posedge i_clk_sys);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1;
		chk(nm, exp, o_rdata);
	endtask : rd
	task automatic smp(input logic [1:0] c, input logic signed [31:0] v, input logic op);
		@(posedge i_clk_sys);
		i_smp_vld <= 1'b1;
		i_smp_chan <= c;
		i_smp_value <= v;
		i_smp_open <= op;
		@(posedge i_clk_sys);
		i_smp_vld <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
	endtask : smp
	task automatic t_conv;
		wr(REG_CHCFG, 32'h10c);
		wr(REG_CHCFG, 32'h139);
		smp(2'd0, 32'sd12345, 1'b0);
		rd(REG_WORD0, 32'd1235, "word0");
		rd(REG_REAL0, 32'd12345, "real0");
		smp(2'd0, -32'sd12346, 1'b0);
		rd(REG_WORD0, 32'hfffffb2d, "word0 neg");
		smp(2'd1, 32'sd330800, 1'b0);
		rd(8'h24, 32'd32767, "word1 sat");
		rd(8'h34, 32'd330800, "real1 full");
		smp(2'd1, -32'sd400000, 1'b0);
		rd(8'h24, 32'hffff8000, "word1 min");
		wr(REG_CTRL, 32'h1);
		smp(2'd0, 32'sd10000, 1'b0);
		rd(REG_WORD0, 32'd2120, "word0 fahr");
		wr(REG_CTRL, 32'h0);
		$display("conversion test done");
	endtask : t_conv
	task automatic t_stat;
		for (int i = 0; i < 4; i++)
		begin
			smp(2'(i), 32'sd4000000, 1'b0);
			rd(REG_STATUS, 32'h1 << 2 * i, "status range");
			smp(2'(i), 32'sd0, 1'b1);
			rd(REG_STATUS, 32'h2 << 2 * i, "status burnout");
			smp(2'(i), 32'sd0, 1'b0);
			rd(REG_STATUS, 32'h0, "status clear");
		end
		$display("status test done");
	endtask : t_stat
	task automatic t_irq;
		chk("irq masked", 32'h0, {31'h0, o_irq});
		rd(REG_IST, 32'hff, "ist all");
		wr(REG_IMASK, 32'h4);
		chk("irq on", 32'h1, {31'h0, o_irq});
		wr(REG_IST, 32'hff);
		rd(REG_IST, 32'h0, "ist cleared");
		chk("irq off", 32'h0, {31'h0, o_irq});
		smp(2'd1, 32'sd4000000, 1'b0);
		chk("irq event", 32'h1, {31'h0, o_irq});
		wr(REG_IMASK, 32'h0);
		chk("irq mask", 32'h0, {31'h0, o_irq});
		smp(2'd1, 32'sd0, 1'b0);
		$display("interrupt test done");
	endtask : t_irq
	task automatic t_dis;
		wr(REG_CHCFG, 32'h00a);
		smp(2'd2, 32'sd0, 1'b1);
		rd(REG_STATUS, 32'h0, "no burnout");
		smp(2'd0, 32'sd5000, 1'b0);
		rd(REG_WORD0, 32'd500, "word0");
		smp(2'd3, 32'sd4000000, 1'b0);
		rd(REG_STATUS, 32'h40, "ch4 range");
		wr(REG_CHCFG, 32'h004);
		rd(REG_WORD0, 32'h0, "word0 off");
		smp(2'd0, 32'sd4000000, 1'b0);
		rd(REG_STATUS, 32'h0, "status off");
		rd(8'h80, 32'h0, "unmapped");
		$display("disable test done");
	endtask : t_dis
	task automatic t_scale;
		wr(REG_ENG_MIN, 32'h0);
		wr(REG_ENG_MAX, 32'd10000);
		wr(REG_RAW_LIM, {16'd20000, 16'd1000});
		wr(REG_ENG0, 32'd5000);
		chk("raw0 mid", 32'd10500, {16'h0, o_raw_output_word[0]});
		wr(8'h4c, 32'd10000);
		chk("raw3 top", 32'd20000, {16'h0, o_raw_output_word[3]});
		wr(REG_ENG0, 32'd15000);
		chk("raw0 over", 32'd29500, {16'h0, o_raw_output_word[0]});
		wr(REG_CTRL, 32'h6);
		chk("raw0 clamp hi", 32'd20000, {16'h0, o_raw_output_word[0]});
		chk("rej60", 32'h1, {31'h0, o_rej60});
		wr(REG_ENG0, -32'sd2000);
		chk("raw0 clamp lo", 32'd1000, {16'h0, o_raw_output_word[0]});
		wr(REG_CTRL, 32'h0);
		$display("scaling test done");
	endtask : t_scale
	initial
	begin
		repeat (16) @(posedge i_clk_sys);
		i_rstn <= 1'b1;
		t_conv();
		t_stat();
		t_irq();
		t_dis();
		t_scale();
		end_of_test();
	end
endmodule : temp_input_status_scaling_bench
